// [psa_unit.sv]
// Overview of operation
// - 24-bit address, PC stepped by two
// - Only table accesses reach configuration space
// - Bit 23 set only for config table accesses
// - Table address is page over effective address in config space, zero over it otherwise
// - Window address is zero, page, low 15
// - Visibility page register is eight bits
// - Low table read returns low word or byte
// - High table read returns upper byte, zeros
// - Upper byte only via high table instructions
// - Window needs address MSb and enable bit
// - Window maps any 16K-word page, X space
// - Window reads return low 16 bits only
// - Window suspended during table accesses
// - Outside repeat, one or two extra cycles
// - Inside repeat, two extra at edge iterations
//
// The plain strobed port and the address map are this design's own decisions.
`timescale 1ns/1ps
`include "psa_params.svh"
module psa_unit (
   input  wire logic              clock,
   input  wire logic              rst_n,
   input  wire logic              clk_en,
   input  wire logic [3:0]        reg_addr,
   input  wire logic [7:0]        reg_wdata,
   input  wire logic              reg_wr,
   input  wire logic              reg_rd,
   output logic      [7:0]        reg_rdata,
   input  wire psa_pkg::psa_req_t core_req,
   output logic      [15:0]       core_rdata,
   output logic                   core_rvalid,
   output logic                   core_is_program,
   output logic      [1:0]        core_extra_cycles,
   output psa_pkg::psa_pm_req_t   pm_req,
   input  wire logic [23:0]       pm_rdata,
   output psa_pkg::psa_pm_req_t   flash_req
);
   logic [7:0]  vis_page_reg;
   logic [7:0]  tbl_page_reg;
   logic [7:0]  core_ctrl_reg;
   logic        tbl_busy_reg;
   logic        rd_pend_reg;
   psa_pkg::psa_op_t rd_op_reg;
   logic        rd_byte_reg;
   logic        rd_bsel_reg;
   logic [23:0] addr_next;
   logic        win_hit;
   logic        is_table;
   logic        is_twr;
   logic [1:0]  extra_next;

   // Pipeline outline: requests are taken on one edge, and the program memory
   // request and the timing answer leave on that same edge; read data are
   // steered on the next edge. The memory must answer combinationally
   // in the cycle that its request stands, or the steering stage would
   // pick up a stale word. No state advances while the clock enable is low.

   // Table address: page above the effective address in config space only
   function automatic logic [23:0] table_addr(input logic [7:0] page,
                                              input logic [15:0] ea);
      if (page[`PSA_TBL_CFG_BIT])
         table_addr = {page, ea};
      else
         table_addr = {8'h00, ea};
   endfunction : table_addr

   // Window address: top bit clear, page in 22:15, low 15 from the address
   function automatic logic [23:0] window_addr(input logic [7:0] page,
                                               input logic [15:0] ea);
      window_addr = {1'b0, page, ea[14:0]};
   endfunction : window_addr

   assign is_table = core_req.op inside {psa_pkg::PSA_OP_TRD_LO, psa_pkg::PSA_OP_TRD_HI,
                                         psa_pkg::PSA_OP_TWR_LO, psa_pkg::PSA_OP_TWR_HI};
   assign is_twr   = core_req.op inside {psa_pkg::PSA_OP_TWR_LO, psa_pkg::PSA_OP_TWR_HI};
   // Window only in upper data half with enable set; never while a table op runs
   assign win_hit  = core_req.valid && core_req.op == psa_pkg::PSA_OP_DATA
                     && core_req.ea[15] && core_ctrl_reg[`PSA_CTRL_VIS_EN]
                     && !tbl_busy_reg;

   // Address mux for every access kind
   always_comb begin
      case (core_req.op)
         psa_pkg::PSA_OP_FETCH:
            addr_next = {1'b0, core_req.pc[22:1], 1'b0};
         psa_pkg::PSA_OP_DATA:
            addr_next = window_addr(vis_page_reg, core_req.ea);
         default:
            addr_next = table_addr(tbl_page_reg, core_req.ea);
      endcase
   end

   // Extra cycle count; short class outside a repeat costs one, others two, repeat middles none
   always_comb begin
      extra_next = 2'h0;
      if (win_hit) begin
         case (core_req.rpt)
            psa_pkg::PSA_RPT_NONE:
               extra_next = core_req.short_class ? `PSA_EXTRA_SHORT
                                                 : `PSA_EXTRA_LONG;
            psa_pkg::PSA_RPT_EDGE:   extra_next = `PSA_EXTRA_LONG;
            psa_pkg::PSA_RPT_MIDDLE: extra_next = 2'h0;
            default:                 extra_next = `PSA_EXTRA_LONG;
         endcase
      end
   end

   // Register writes; the page register is a full eight bits
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         vis_page_reg  <= `PSA_VIS_PAGE_RST;
         tbl_page_reg  <= `PSA_TBL_PAGE_RST;
         core_ctrl_reg <= `PSA_CTRL_RST;
      end else if (clk_en && reg_wr) begin
         case (reg_addr)
            `PSA_OFF_VIS_PAGE:  vis_page_reg  <= reg_wdata;
            `PSA_OFF_TBL_PAGE:  tbl_page_reg  <= reg_wdata;
            `PSA_OFF_CORE_CTRL: core_ctrl_reg <= reg_wdata;
            default: ;
         endcase
      end
   end

   // Register reads answer one cycle later; unmapped reads return zero
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         reg_rdata <= 8'h00;
      end else if (clk_en) begin
         reg_rdata <= 8'h00;
         if (reg_rd) begin
            case (reg_addr)
               `PSA_OFF_VIS_PAGE:  reg_rdata <= vis_page_reg;
               `PSA_OFF_TBL_PAGE:  reg_rdata <= tbl_page_reg;
               `PSA_OFF_CORE_CTRL: reg_rdata <= core_ctrl_reg;
               `PSA_OFF_STATUS:    reg_rdata <= {6'h00, rd_pend_reg, tbl_busy_reg};
               default:            reg_rdata <= 8'h00;
            endcase
         end
      end
   end

   // Table-in-progress flag suppresses the window in the cycle that follows
   // Only one cycle of suppression: a table access occupies the memory
   // port for exactly one request slot, so a longer hold would only cost
   // window bandwidth without protecting anything.
   always_ff @(posedge clock) begin
      if (!rst_n)
         tbl_busy_reg <= 1'b0;
      else if (clk_en)
         tbl_busy_reg <= core_req.valid && is_table;
   end

   // Program memory request; fetch, table reads and window reads
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         pm_req            <= '0;
         core_is_program   <= 1'b0;
         core_extra_cycles <= 2'h0;
      end else if (clk_en) begin
         pm_req.valid      <= core_req.valid && !is_twr
                              && (core_req.op != psa_pkg::PSA_OP_DATA || win_hit);
         pm_req.write      <= 1'b0;
         pm_req.high       <= core_req.op == psa_pkg::PSA_OP_TRD_HI;
         pm_req.addr       <= addr_next;
         pm_req.wdata      <= 16'h0000;
         core_is_program   <= win_hit;
         core_extra_cycles <= extra_next;
      end
   end

   // Table writes go to the flash programming logic with the formed address
   // Latching and timing of the write belong to that logic, so the request
   // is offered for a single cycle and never reaches the read port.
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         flash_req <= '0;
      end else if (clk_en) begin
         flash_req.valid <= core_req.valid && is_twr;
         flash_req.write <= 1'b1;
         flash_req.high  <= core_req.op == psa_pkg::PSA_OP_TWR_HI;
         flash_req.addr  <= addr_next;
         flash_req.wdata <= core_req.wdata;
      end
   end

   // Remember how to steer the read data that returns next cycle
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rd_pend_reg <= 1'b0;
         rd_op_reg   <= psa_pkg::PSA_OP_FETCH;
         rd_byte_reg <= 1'b0;
         rd_bsel_reg <= 1'b0;
      end else if (clk_en) begin
         rd_pend_reg <= core_req.valid && (win_hit
                        || core_req.op == psa_pkg::PSA_OP_TRD_LO
                        || core_req.op == psa_pkg::PSA_OP_TRD_HI);
         rd_op_reg   <= core_req.op;
         rd_byte_reg <= core_req.byte_mode;
         rd_bsel_reg <= core_req.ea[0];
      end
   end

   // Data steering; the upper program byte leaves only on a high table read
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         core_rdata  <= 16'h0000;
         core_rvalid <= 1'b0;
      end else if (clk_en) begin
         core_rvalid <= rd_pend_reg;
         core_rdata  <= 16'h0000;
         if (rd_pend_reg) begin
            case (rd_op_reg)
               psa_pkg::PSA_OP_TRD_HI:
                  core_rdata <= (rd_byte_reg && rd_bsel_reg) ? 16'h0000
                                                             : {8'h00, pm_rdata[23:16]};
               psa_pkg::PSA_OP_TRD_LO:
                  core_rdata <= !rd_byte_reg ? pm_rdata[15:0]
                              : {8'h00, rd_bsel_reg ? pm_rdata[15:8] : pm_rdata[7:0]};
               default:
                  core_rdata <= rd_byte_reg
                              ? {8'h00, rd_bsel_reg ? pm_rdata[15:8] : pm_rdata[7:0]}
                              : pm_rdata[15:0];
            endcase
         end
      end
   end

   // Window address and page relation
   a_window_addr: assert property (@(posedge clock) disable iff (!rst_n)
      (clk_en && win_hit) |=> pm_req.valid && pm_req.addr[23] == 1'b0
         && pm_req.addr[14:0] == $past(core_req.ea[14:0])
         && pm_req.addr[22:15] == $past(vis_page_reg))
      else $error("window address wrong");
   a_fetch_top_clear: assert property (@(posedge clock) disable iff (!rst_n)
      (clk_en && core_req.valid && core_req.op == psa_pkg::PSA_OP_FETCH)
         |=> pm_req.addr[23] == 1'b0 && pm_req.addr[0] == 1'b0)
      else $error("fetch address has bit 23 or bit 0 set");
   a_table_user: assert property (@(posedge clock) disable iff (!rst_n)
      (clk_en && core_req.valid && is_table && !tbl_page_reg[7])
         |=> (pm_req.addr | flash_req.addr) == {8'h00, $past(core_req.ea)})
      else $error("user table address wrong");
   a_no_overlap: assert property (@(posedge clock) disable iff (!rst_n)
      (clk_en && core_req.valid && is_table) |=> !win_hit)
      else $error("window active during table access");
   sequence s_win_hit;
      clk_en && win_hit;
   endsequence
   a_extra_count: assert property (@(posedge clock) disable iff (!rst_n)
      s_win_hit ##0 (core_req.rpt == psa_pkg::PSA_RPT_MIDDLE)
         |=> core_extra_cycles == 2'h0)
      else $error("middle iteration took extra cycles");
   a_extra_short: assert property (@(posedge clock) disable iff (!rst_n)
      s_win_hit ##0 (core_req.rpt == psa_pkg::PSA_RPT_NONE && core_req.short_class)
         |=> core_extra_cycles == 2'h1)
      else $error("short class extra cycles wrong");
   a_high_read: assert property (@(posedge clock) disable iff (!rst_n)
      (clk_en && rd_pend_reg && rd_op_reg == psa_pkg::PSA_OP_TRD_HI)
         |=> core_rdata[15:8] == 8'h00)
      else $error("high read upper byte not zero");
   a_window_low16: assert property (@(posedge clock) disable iff (!rst_n)
      (clk_en && rd_pend_reg && rd_op_reg == psa_pkg::PSA_OP_DATA && !rd_byte_reg)
         |=> core_rdata == $past(pm_rdata[15:0]))
      else $error("window read data wrong");
   a_twr_flash: assert property (@(posedge clock) disable iff (!rst_n)
      (clk_en && core_req.valid && is_twr) |=> flash_req.valid && !pm_req.valid)
      else $error("table write not passed to flash logic");

   // Fetch address steps by two from the counter
   a_fetch_step: assert property (@(posedge clock) disable iff (!rst_n)
      (clk_en && core_req.valid && core_req.op == psa_pkg::PSA_OP_FETCH)
         |=> pm_req.addr == {1'b0, $past(core_req.pc[22:1]), 1'b0})
      else $error("fetch address not stepped by two");

   // Anything but a table access stays in user space
   a_user_only: assert property (@(posedge clock) disable iff (!rst_n)
      (clk_en && core_req.valid && !is_table)
         |=> pm_req.addr[23] == 1'b0)
      else $error("non-table access left user space");

   // Configuration table access puts the page above the address
   a_table_config: assert property (@(posedge clock) disable iff (!rst_n)
      (clk_en && core_req.valid && is_table && tbl_page_reg[7])
         |=> pm_req.addr == {$past(tbl_page_reg), $past(core_req.ea)})
      else $error("configuration table address wrong");

   // Page register takes a full byte
   a_page_write: assert property (@(posedge clock) disable iff (!rst_n)
      (clk_en && reg_wr && reg_addr == `PSA_OFF_VIS_PAGE)
         |=> vis_page_reg == $past(reg_wdata))
      else $error("visibility page write lost");

   // Low table word read passes the low program word
   a_low_word: assert property (@(posedge clock) disable iff (!rst_n)
      (clk_en && rd_pend_reg && rd_op_reg == psa_pkg::PSA_OP_TRD_LO && !rd_byte_reg)
         |=> core_rdata == $past(pm_rdata[15:0]))
      else $error("low table word wrong");

   // Low table byte read leaves the upper data byte clear
   a_low_byte: assert property (@(posedge clock) disable iff (!rst_n)
      (clk_en && rd_pend_reg && rd_op_reg == psa_pkg::PSA_OP_TRD_LO && rd_byte_reg)
         |=> core_rdata[15:8] == 8'h00)
      else $error("low table byte upper half not zero");

   // High table read returns the upper program byte
   a_high_value: assert property (@(posedge clock) disable iff (!rst_n)
      (clk_en && rd_pend_reg && rd_op_reg == psa_pkg::PSA_OP_TRD_HI
         && !(rd_byte_reg && rd_bsel_reg))
         |=> core_rdata[7:0] == $past(pm_rdata[23:16]))
      else $error("high table byte wrong");

   // High table byte read with select one returns zero
   a_high_zero: assert property (@(posedge clock) disable iff (!rst_n)
      (clk_en && rd_pend_reg && rd_op_reg == psa_pkg::PSA_OP_TRD_HI
         && rd_byte_reg && rd_bsel_reg)
         |=> core_rdata == 16'h0000)
      else $error("high table odd byte not zero");

   // Lower data half or disabled window never reaches program memory
   a_window_gate: assert property (@(posedge clock) disable iff (!rst_n)
      (clk_en && core_req.valid && core_req.op == psa_pkg::PSA_OP_DATA
         && (!core_req.ea[15] || !core_ctrl_reg[`PSA_CTRL_VIS_EN]))
         |=> !core_is_program && !pm_req.valid)
      else $error("window used without address bit or enable");

   // Repeat edge iterations cost two cycles
   a_extra_edge: assert property (@(posedge clock) disable iff (!rst_n)
      s_win_hit ##0 (core_req.rpt == psa_pkg::PSA_RPT_EDGE)
         |=> core_extra_cycles == 2'h2)
      else $error("repeat edge extra cycles wrong");

   // Long class outside a repeat costs two cycles
   a_extra_long: assert property (@(posedge clock) disable iff (!rst_n)
      s_win_hit ##0 (core_req.rpt == psa_pkg::PSA_RPT_NONE && !core_req.short_class)
         |=> core_extra_cycles == 2'h2)
      else $error("long class extra cycles wrong");

   // No window, no extra cycles
   a_extra_none: assert property (@(posedge clock) disable iff (!rst_n)
      (clk_en && !win_hit) |=> core_extra_cycles == 2'h0)
      else $error("extra cycles without window access");

   // Read data flagged only for reads that were issued
   a_rvalid_reads: assert property (@(posedge clock) disable iff (!rst_n)
      (clk_en && !rd_pend_reg) |=> !core_rvalid)
      else $error("read valid without a pending read");

   // Table writes never start a read
   a_twr_no_read: assert property (@(posedge clock) disable iff (!rst_n)
      (clk_en && core_req.valid && is_twr) |=> !rd_pend_reg)
      else $error("table write started a read");

   // Clock enable low freezes state and outputs
   a_freeze: assert property (@(posedge clock) disable iff (!rst_n)
      !clk_en |=> $stable(pm_req) && $stable(core_rdata) && $stable(vis_page_reg)
         && $stable(reg_rdata))
      else $error("state moved while clock enable low");

   // Register read data stand for one cycle only
   a_reg_read_once: assert property (@(posedge clock) disable iff (!rst_n)
      (clk_en && !reg_rd) |=> reg_rdata == 8'h00)
      else $error("register read data held too long");
endmodule : psa_unit

// [psa_params.svh]
`ifndef PSA_PARAMS_SVH
`define PSA_PARAMS_SVH
// Register offsets on the plain register port
`define PSA_OFF_VIS_PAGE   4'h0
`define PSA_OFF_TBL_PAGE   4'h1
`define PSA_OFF_CORE_CTRL  4'h2
`define PSA_OFF_STATUS     4'h3
// Field positions
`define PSA_CTRL_VIS_EN    2
`define PSA_TBL_CFG_BIT    7
// Reset values
`define PSA_VIS_PAGE_RST   8'h00
`define PSA_TBL_PAGE_RST   8'h00
`define PSA_CTRL_RST       8'h00
// Extra-cycle counts for window accesses
`define PSA_EXTRA_SHORT    2'h1
`define PSA_EXTRA_LONG     2'h2
`endif

// [psa_pkg.sv]
package psa_pkg;
   typedef enum logic [2:0] {
      PSA_OP_FETCH, PSA_OP_DATA, PSA_OP_TRD_LO, PSA_OP_TRD_HI,
      PSA_OP_TWR_LO, PSA_OP_TWR_HI
   } psa_op_t;
   typedef enum logic [1:0] {
      PSA_RPT_NONE, PSA_RPT_EDGE, PSA_RPT_MIDDLE
   } psa_rpt_t;
   typedef struct packed {
      logic           valid;
      psa_op_t        op;
      logic [15:0]    ea;
      logic [22:0]    pc;
      logic           byte_mode;
      logic           short_class;
      psa_rpt_t       rpt;
      logic [15:0]    wdata;
   } psa_req_t;
   typedef struct packed {
      logic           valid;
      logic           write;
      logic           high;
      logic [23:0]    addr;
      logic [15:0]    wdata;
   } psa_pm_req_t;
endpackage : psa_pkg

// [psa_prog_mem.sv]
`timescale 1ns/1ps
// Program memory seen by the unit: answers in the same cycle as the request
module psa_prog_mem (
   input  wire logic                 clock,
   input  wire psa_pkg::psa_pm_req_t pm_req,
   output logic [23:0]               pm_rdata
);
   logic flip_reg = 1'b0;
   // Idle pattern flips every cycle so a late sample never sees a stale word
   always_ff @(posedge clock) begin
      flip_reg <= ~flip_reg;
   end
   // Word content is a fixed pattern of the address
   assign pm_rdata = pm_req.valid ? {pm_req.addr[7:0] ^ 8'h3c, pm_req.addr[15:0] ^ 16'h9a51}
                                  : {24{flip_reg}} ^ 24'h5a5a5a;
endmodule : psa_prog_mem

// [psa_unit_tb.sv]
`timescale 1ns/1ps
module psa_unit_tb;
   logic                 clock = 1'b0;
   logic                 rst_n = 1'b0;
   logic                 clk_en = 1'b1;
   logic [3:0]           reg_addr = 4'h0;
   logic [7:0]           reg_wdata = 8'h00;
   logic                 reg_wr = 1'b0;
   logic                 reg_rd = 1'b0;
   logic [7:0]           reg_rdata;
   psa_pkg::psa_req_t    core_req = '0;
   logic [15:0]          core_rdata;
   logic                 core_rvalid;
   logic                 core_is_program;
   logic [1:0]           core_extra_cycles;
   psa_pkg::psa_pm_req_t pm_req;
   psa_pkg::psa_pm_req_t flash_req;
   logic [23:0]          pm_rdata;
   int                   mismatches = 0;
   int                   comparisons = 0;
   // Output snapshots taken one nanosecond after each edge
   psa_pkg::psa_pm_req_t s_pm [3];
   psa_pkg::psa_pm_req_t s_fl [3];
   logic                 s_isp [3];
   logic [1:0]           s_ex [3];
   logic [15:0]          s_rd [3];
   logic                 s_rv [3];

   always #5 clock = ~clock;

   psa_unit psa_unit_inst (.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .core_req(core_req), .core_rdata(core_rdata), .core_rvalid(core_rvalid),
      .core_is_program(core_is_program), .core_extra_cycles(core_extra_cycles),
      .pm_req(pm_req), .pm_rdata(pm_rdata), .flash_req(flash_req));
   psa_prog_mem psa_prog_mem_inst (.clock(clock), .pm_req(pm_req), .pm_rdata(pm_rdata));

   function automatic logic [23:0] word_at(input logic [23:0] a);
      return {a[7:0] ^ 8'h3c, a[15:0] ^ 16'h9a51};
   endfunction : word_at

   function automatic psa_pkg::psa_req_t mk(input psa_pkg::psa_op_t op, input logic [15:0] ea,
         input logic [22:0] pc = 23'h0, input logic bm = 1'b0, input logic sc = 1'b0,
         input psa_pkg::psa_rpt_t rp = psa_pkg::PSA_RPT_NONE);
      return '{1'b1, op, ea, pc, bm, sc, rp, 16'hbeef};
   endfunction : mk

   task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_addr  <= a;
      reg_wdata <= d;
      reg_wr    <= 1'b1;
      @(posedge clock);
      reg_wr    <= 1'b0;
   endtask : wr

   // Read data stand only in the cycle after the strobe
   task automatic rdc(input logic [3:0] a, input logic [7:0] e);
      @(posedge clock);
      reg_addr <= a;
      reg_rd   <= 1'b1;
      @(posedge clock);
      reg_rd   <= 1'b0;
      #1 chk(reg_rdata, e, "register read");
   endtask : rdc

   task automatic snap(input int k);
      #1;
      s_pm[k]  = pm_req;
      s_fl[k]  = flash_req;
      s_isp[k] = core_is_program;
      s_ex[k]  = core_extra_cycles;
      s_rd[k]  = core_rdata;
      s_rv[k]  = core_rvalid;
   endtask : snap

   // Request a, then b back to back; a's answers in s_*[0] and [1], b's in [1] and [2]
   task automatic run(input psa_pkg::psa_req_t a, input psa_pkg::psa_req_t b = '0);
      @(posedge clock);
      core_req <= a;
      @(posedge clock);
      core_req <= b;
      snap(0);
      @(posedge clock);
      core_req <= '0;
      snap(1);
      @(posedge clock);
      snap(2);
   endtask : run

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask : complete_run

   // Whole sequence needs about 135 cycles
   initial begin : watchdog
      repeat (5000) @(posedge clock);
      mismatches++;
      $display("unexpected at %0t: run did not finish", $time);
      complete_run();
   end

   initial begin : main_seq
      logic [23:0] adr;
      logic [15:0] ex;
      logic [15:0] ea;
      logic [7:0]  tp;
      repeat (10) @(posedge clock);
      rst_n <= 1'b1;
      // Registers: reset values, read back, read-only status, unmapped index
      for (int i = 0; i < 3; i++) rdc(i[3:0], 8'h00);
      wr(4'h0, 8'ha5);
      rdc(4'h0, 8'ha5);
      wr(4'h3, 8'hff);
      rdc(4'h3, 8'h00);
      rdc(4'h5, 8'h00);
      // Clock enable low: a write must be ignored and the old page kept
      @(posedge clock);
      clk_en <= 1'b0;
      wr(4'h0, 8'h11);
      clk_en <= 1'b1;
      rdc(4'h0, 8'ha5);
      $display("registers test done");
      // Fetch at the top of user space and at an odd counter value
      run(mk(psa_pkg::PSA_OP_FETCH, 16'h0, 23'h7fffff));
      chk(s_pm[0].addr, 24'h7ffffe, "fetch top");
      run(mk(psa_pkg::PSA_OP_FETCH, 16'h0, 23'h000003));
      chk(s_pm[0].addr, 24'h000002, "fetch step");
      $display("fetch test done");
      // Table reads: user and configuration pages, word and both byte selects
      for (int p = 0; p < 2; p++) begin
         tp = p ? 8'h85 : 8'h05;
         wr(4'h1, tp);
         for (int k = 0; k < 6; k++) begin
            ea  = (k % 3 == 2) ? 16'h1235 : 16'h1234;
            adr = tp[7] ? {tp, ea} : {8'h00, ea};
            run(mk(k < 3 ? psa_pkg::PSA_OP_TRD_LO : psa_pkg::PSA_OP_TRD_HI, ea, 23'h0,
                   k % 3 != 0));
            case (k)
               0: ex = word_at(adr) >> 0;
               1: ex = {8'h00, word_at(adr) >> 0} & 16'h00ff;
               2: ex = (word_at(adr) >> 8) & 16'h00ff;
               3, 4: ex = (word_at(adr) >> 16) & 16'h00ff;
               default: ex = 16'h0000;
            endcase
            chk(s_pm[0].addr, adr, "table address");
            chk(s_rv[1], 1'b1, "table read valid");
            if (k % 3 == 0) chk(s_rd[1], ex, "table word");
            else chk(s_rd[1][7:0], ex[7:0], "table byte");
         end
      end
      // Table writes go to the flash logic with the formed address
      for (int k = 0; k < 2; k++) begin
         run(mk(k ? psa_pkg::PSA_OP_TWR_HI : psa_pkg::PSA_OP_TWR_LO, 16'h0a0c));
         chk({s_fl[0].valid, s_fl[0].write, s_fl[0].high}, {2'b11, k[0]}, "flash");
         chk(s_fl[0].addr, 24'h850a0c, "flash address");
         chk(s_fl[0].wdata, 16'hbeef, "flash data");
      end
      $display("table test done");
      // Window: top page, each timing class
      wr(4'h2, 8'h04);
      wr(4'h0, 8'hff);
      for (int k = 0; k < 4; k++) begin
         run(mk(psa_pkg::PSA_OP_DATA, 16'hfffe, 23'h0, 1'b0, k != 1, k < 2 ?
                psa_pkg::PSA_RPT_NONE : (k == 2 ? psa_pkg::PSA_RPT_EDGE : psa_pkg::PSA_RPT_MIDDLE)));
         chk(s_pm[0].addr, 24'h7ffffe, "window address");
         chk(s_isp[0], 1'b1, "window hit");
         chk(s_ex[0], k == 0 ? 2'h1 : (k == 3 ? 2'h0 : 2'h2), "extra");
         chk({s_rv[1], s_rd[1]}, {1'b1, 16'hfffe ^ 16'h9a51}, "window data");
      end
      $display("window test done");
      // Refusals: low half, right after a table read, window disabled
      run(mk(psa_pkg::PSA_OP_DATA, 16'h7ffe));
      chk({s_pm[0].valid, s_isp[0], s_rv[1]}, 3'b000, "low half");
      run(mk(psa_pkg::PSA_OP_TRD_LO, 16'h0002), mk(psa_pkg::PSA_OP_DATA, 16'hfffe));
      chk({s_pm[1].valid, s_isp[1], s_rv[2]}, 3'b000, "after table");
      wr(4'h2, 8'h00);
      run(mk(psa_pkg::PSA_OP_DATA, 16'hfffe));
      chk({s_pm[0].valid, s_isp[0], s_rv[1]}, 3'b000, "disabled");
      $display("refusal test done");
      complete_run();
   end
endmodule : psa_unit_tb
